// >>> inc/lrg_regs.svh
`ifndef LRG_REGS_SVH
`define LRG_REGS_SVH

// Sub-addresses on the serial link, one byte each
`define LRG_A_LOC_SEL    8'h00
`define LRG_A_ACCESS     8'h04
`define LRG_A_INT_EN     8'h08
`define LRG_A_INT_STS    8'h10
`define LRG_A_CAP        8'h14
`define LRG_A_STS        8'h18
`define LRG_A_FIFO       8'h24
`define LRG_A_DEV_ADDR   8'h38
`define LRG_A_CSUM_EN    8'h40
`define LRG_A_DATA_CSUM  8'h44
`define LRG_A_ID         8'h48
`define LRG_A_REV        8'h4C
`define LRG_A_HASH_START 8'h50
`define LRG_A_HASH_DATA  8'h54
`define LRG_A_HASH_END   8'h58

// Local register port, byte addresses of 32-bit words
`define LRG_B_INT_STS    8'h00
`define LRG_B_INT_MASK   8'h04
`define LRG_B_STATE      8'h08
`define LRG_B_DEV_ADDR   8'h0C

// Access register fields
`define LRG_ACC_REQ      1
`define LRG_ACC_ACTIVE   5
`define LRG_ACC_VALID    8'h80
`define LRG_ACC_ACT_VAL  8'h20

// Event bits of the interrupt status
`define LRG_EV_W         6
`define LRG_EV_CMD       0
`define LRG_EV_HSTART    1
`define LRG_EV_HEND      2
`define LRG_EV_NACK      3
`define LRG_EV_GRANT     4
`define LRG_EV_CORE      5

// Reset values and fixed codes
`define LRG_DEV_ADDR_RST 7'h2E
`define LRG_BLOCKED      8'hFF
`define LRG_HASH_LOC     8'h04
`define LRG_BITS_BYTE    4'h8
`define LRG_LAST_BIT     4'h7

`endif

// >>> inc/lrg_pkg.sv
package lrg_pkg;

   typedef enum logic [3:0] {
      PH_IDLE,
      PH_ADDR,
      PH_AACK,
      PH_SUB,
      PH_SACK,
      PH_WR,
      PH_WACK,
      PH_RD,
      PH_RACK
   } lrg_phase_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } lrg_bus_req_t;

   typedef struct packed {
      logic       fifo_wr;
      logic       fifo_pop;
      logic       sts_wr;
      logic       hash_start;
      logic       hash_data;
      logic       hash_end;
      logic [7:0] data;
   } lrg_cmd_t;

   typedef struct packed {
      lrg_phase_t  phase;
      logic        scl_q;
      logic        sda_q;
      logic [3:0]  cnt;
      logic [7:0]  sh;
      logic [7:0]  tx;
      logic        rw;
      logic        acked;
      logic [7:0]  sub;
      logic        sda_oe;
      logic        sda_o;
      logic        grant;
      logic [7:0]  grant_loc;
      logic [7:0]  loc_sel;
      logic [5:0]  int_sts;
      logic [5:0]  int_en;
      logic        csum_en;
      logic [7:0]  csum;
      logic [6:0]  dev_addr;
      lrg_cmd_t    cmd;
      logic [31:0] bus_rdata;
      logic        irq;
   } lrg_regs_t;

endpackage : lrg_pkg

// >>> logic/lrg_sync.sv
`timescale 1ns/1ps
`default_nettype none
module lrg_sync
#(
   parameter int         WIDTH   = 2,
   parameter logic [1:0] RST_VAL = 2'h3
)(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);

   logic [1:0][WIDTH-1:0] st_r;
   logic [1:0][WIDTH-1:0] st_nxt;

   if (WIDTH < 1 || WIDTH > 2)
   begin : g_bad_width
      $error("lrg_sync: WIDTH must be 1 or 2");
   end

   always_comb
   begin
      st_nxt[0] = d;
      st_nxt[1] = st_r[0];
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_r[0] <= RST_VAL[WIDTH-1:0];
         st_r[1] <= RST_VAL[WIDTH-1:0];
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r[1];

endmodule : lrg_sync
`default_nettype wire

// >>> logic/lrg_gate.sv
// What this block does
// [RULE1] Ungranted locality: status/data/hash reads 0xFF, writes dropped
// [RULE2] Access, select, enable, address registers always usable
// [RULE3] Granted locality reads data, status; updates status
// [RULE4] Granted locality's data writes become command bytes
// [RULE5] Hash start with no grant grants locality four
// [RULE6] Granted hash end accepted, drops the grant
// [RULE7] Address mismatch answers NACK
// [RULE8] Busy core may NACK own address
// [RULE9] Master repeats whole cycle after NACK
// [RULE10] Master waits about 2ms before retry
// [RULE11] Read-only registers readable, writes ignored
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lrg_regs.svh"
module lrg_gate
   import lrg_pkg::*;
#(
   parameter logic [7:0] ID_VALUE  = 8'h5A, // Arbitrary value
   parameter logic [7:0] REV_VALUE = 8'h01, // Arbitrary value
   parameter logic [7:0] CAP_VALUE = 8'h00
)(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         scl_i,
   input  wire logic         sda_i,
   output var  logic         sda_o,
   output var  logic         sda_oe,
   input  wire lrg_bus_req_t bus_req,
   output var  logic [31:0]  bus_rdata,
   input  wire logic         core_busy,
   input  wire logic [7:0]   core_sts,
   input  wire logic [7:0]   core_fifo_data,
   input  wire logic         core_evt,
   output var  lrg_cmd_t     cmd,
   output var  logic         irq
);

   lrg_regs_t  r;
   lrg_regs_t  n;
   logic [1:0] pin_s;
   logic       scl_s;
   logic       sda_s;
   logic       perm;

   // Pins come from another domain
   lrg_sync #(
      .WIDTH   (2),
      .RST_VAL (2'h3)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({scl_i, sda_i}),
      .q     (pin_s)
   );

   assign scl_s = pin_s[1];
   assign sda_s = pin_s[0];

   // Accessing locality is the one holding the grant
   assign perm = r.grant && (r.grant_loc == r.loc_sel);

   // Data and hash data ports stay put so bursts hit the same port
   function automatic logic [7:0] step_sub(input logic [7:0] a);
      logic [7:0] v;
      v = a + 8'h01;
      if (a == `LRG_A_FIFO || a == `LRG_A_HASH_DATA)
      begin
         v = a;
      end
      return v;
   endfunction : step_sub

   function automatic logic [7:0] rd_val(input logic [7:0] a);
      logic [7:0] v;
      v = `LRG_BLOCKED;
      case (a)
         `LRG_A_LOC_SEL:   v = r.loc_sel; // RULE2
         `LRG_A_ACCESS:    v = `LRG_ACC_VALID | (perm ? `LRG_ACC_ACT_VAL : 8'h00); // RULE2
         `LRG_A_INT_EN:    v = {2'b00, r.int_en}; // RULE2
         `LRG_A_INT_STS:   v = {2'b00, r.int_sts}; // RULE2
         `LRG_A_DEV_ADDR:  v = {1'b0, r.dev_addr}; // RULE2
         `LRG_A_CSUM_EN:   v = {7'h00, r.csum_en}; // RULE2
         `LRG_A_CAP:       v = CAP_VALUE; // RULE11
         `LRG_A_DATA_CSUM: v = r.csum; // RULE11
         `LRG_A_ID:        v = ID_VALUE; // RULE11
         `LRG_A_REV:       v = REV_VALUE; // RULE11
         `LRG_A_STS:
         begin
            if (perm)
            begin
               v = core_sts; // RULE3
            end
         end
         `LRG_A_FIFO:
         begin
            if (perm)
            begin
               v = core_fifo_data; // RULE3
            end
         end
         // Hash registers and holes read as blocked
         default: v = `LRG_BLOCKED; // RULE1
      endcase
      return v;
   endfunction : rd_val

   always_comb
   begin
      logic       rise;
      logic       fall;
      logic       start;
      logic       stop;
      logic       wr_go;
      logic       rd_go;
      logic [7:0] wr_addr;
      logic [7:0] wr_data;
      logic [7:0] rd_addr;
      logic [7:0] rv;
      logic [5:0] ev;
      logic [5:0] clr;
      n       = r;
      rise    = scl_s & ~r.scl_q;
      fall    = ~scl_s & r.scl_q;
      start   = scl_s & r.scl_q & r.sda_q & ~sda_s;
      stop    = scl_s & r.scl_q & ~r.sda_q & sda_s;
      wr_go   = 1'b0;
      rd_go   = 1'b0;
      wr_addr = r.sub;
      wr_data = r.sh;
      rd_addr = r.sub;
      rv      = `LRG_BLOCKED;
      ev      = '0;
      clr     = '0;
      n.scl_q = scl_s;
      n.sda_q = sda_s;
      n.cmd   = '0;
      n.sda_o = 1'b0;

      // Link sequencing; START or STOP aborts any phase
      if (start)
      begin
         n.phase  = PH_ADDR;
         n.cnt    = '0;
         n.sda_oe = 1'b0;
      end
      else if (stop)
      begin
         n.phase  = PH_IDLE;
         n.sda_oe = 1'b0;
      end
      else if (rise)
      begin
         case (r.phase)
            PH_ADDR, PH_SUB, PH_WR:
            begin
               n.sh  = {r.sh[6:0], sda_s};
               n.cnt = r.cnt + 4'h1;
            end
            PH_RACK: n.acked = ~sda_s;
            default: n.acked = r.acked;
         endcase
      end
      else if (fall)
      begin
         case (r.phase)
            PH_ADDR:
            begin
               if (r.cnt == `LRG_BITS_BYTE)
               begin
                  n.cnt = '0;
                  if (r.sh[7:1] == r.dev_addr && !core_busy) // RULE7 RULE8
                  begin
                     n.sda_oe = 1'b1;
                     n.rw     = r.sh[0];
                     n.phase  = PH_AACK;
                  end
                  else
                  begin
                     // Nothing is kept; the master repeats the cycle
                     n.phase = PH_IDLE; // RULE9
                     ev[`LRG_EV_NACK] = r.sh[7:1] == r.dev_addr;
                  end
               end
            end
            PH_AACK:
            begin
               if (r.rw)
               begin
                  rd_go   = 1'b1;
                  rd_addr = r.sub;
               end
               else
               begin
                  n.sda_oe = 1'b0;
                  n.phase  = PH_SUB;
               end
            end
            PH_SUB:
            begin
               if (r.cnt == `LRG_BITS_BYTE)
               begin
                  n.sub    = r.sh;
                  n.sda_oe = 1'b1;
                  n.cnt    = '0;
                  n.phase  = PH_SACK;
               end
            end
            PH_SACK, PH_WACK:
            begin
               n.sda_oe = 1'b0;
               n.phase  = PH_WR;
            end
            PH_WR:
            begin
               if (r.cnt == `LRG_BITS_BYTE)
               begin
                  wr_go    = 1'b1;
                  n.sub    = step_sub(r.sub);
                  n.sda_oe = 1'b1;
                  n.cnt    = '0;
                  n.phase  = PH_WACK;
               end
            end
            PH_RD:
            begin
               if (r.cnt == `LRG_LAST_BIT)
               begin
                  n.sda_oe = 1'b0;
                  n.phase  = PH_RACK;
               end
               else
               begin
                  n.cnt    = r.cnt + 4'h1;
                  n.tx     = {r.tx[6:0], 1'b0};
                  n.sda_oe = ~r.tx[6];
               end
            end
            PH_RACK:
            begin
               if (r.acked)
               begin
                  rd_go   = 1'b1;
                  rd_addr = step_sub(r.sub);
                  n.sub   = step_sub(r.sub);
               end
               else
               begin
                  n.phase = PH_IDLE;
               end
            end
            default: n.phase = PH_IDLE;
         endcase
      end

      // Byte out: open drain, low driven for a zero bit
      if (rd_go)
      begin
         rv       = rd_val(rd_addr);
         n.tx     = rv;
         n.sda_oe = ~rv[7];
         n.cnt    = '0;
         n.phase  = PH_RD;
         if (rd_addr == `LRG_A_FIFO && perm)
         begin
            n.cmd.fifo_pop = 1'b1; // RULE3
         end
      end

      // Local register port; link writes below take precedence
      n.bus_rdata = '0;
      if (bus_req.rd)
      begin
         case (bus_req.addr)
            `LRG_B_INT_STS:  n.bus_rdata = {26'h000_0000, r.int_sts};
            `LRG_B_INT_MASK: n.bus_rdata = {26'h000_0000, r.int_en};
            `LRG_B_STATE:    n.bus_rdata = {15'h0000, r.grant, r.grant_loc, r.loc_sel};
            `LRG_B_DEV_ADDR: n.bus_rdata = {25'h000_0000, r.dev_addr};
            default:         n.bus_rdata = '0;
         endcase
         if (bus_req.addr == `LRG_B_INT_STS)
         begin
            clr = r.int_sts;
         end
      end
      if (bus_req.wr)
      begin
         case (bus_req.addr)
            `LRG_B_INT_MASK: n.int_en = bus_req.wdata[5:0];
            `LRG_B_DEV_ADDR: n.dev_addr = bus_req.wdata[6:0];
            default:         n.int_en = r.int_en;
         endcase
      end

      // Link register writes; status, data, hash data and hash end gated by the grant
      if (wr_go)
      begin
         case (wr_addr)
            `LRG_A_LOC_SEL:  n.loc_sel = wr_data; // RULE2
            `LRG_A_INT_EN:   n.int_en = wr_data[5:0]; // RULE2
            `LRG_A_INT_STS:  clr = clr | wr_data[5:0]; // RULE2
            `LRG_A_DEV_ADDR: n.dev_addr = wr_data[6:0]; // RULE2
            `LRG_A_CSUM_EN:
            begin
               n.csum_en = wr_data[0]; // RULE2
               n.csum    = '0;
            end
            `LRG_A_ACCESS:
            begin
               if (wr_data[`LRG_ACC_REQ] && !r.grant) // RULE2
               begin
                  n.grant     = 1'b1;
                  n.grant_loc = r.loc_sel;
                  ev[`LRG_EV_GRANT] = 1'b1;
               end
               else if (wr_data[`LRG_ACC_ACTIVE] && perm)
               begin
                  n.grant = 1'b0;
                  ev[`LRG_EV_GRANT] = 1'b1;
               end
            end
            `LRG_A_STS:
            begin
               if (perm) // RULE1
               begin
                  n.cmd.sts_wr = 1'b1; // RULE3
                  n.cmd.data   = wr_data;
               end
            end
            `LRG_A_FIFO:
            begin
               if (perm) // RULE1
               begin
                  n.cmd.fifo_wr = 1'b1; // RULE4
                  n.cmd.data    = wr_data;
                  ev[`LRG_EV_CMD] = 1'b1;
                  if (r.csum_en)
                  begin
                     n.csum = r.csum + wr_data;
                  end
               end
            end
            `LRG_A_HASH_START:
            begin
               if (!r.grant)
               begin
                  n.grant        = 1'b1; // RULE5
                  n.grant_loc    = `LRG_HASH_LOC;
                  n.cmd.hash_start = 1'b1;
                  n.csum         = '0;
                  ev[`LRG_EV_HSTART] = 1'b1;
                  ev[`LRG_EV_GRANT]  = 1'b1;
               end
               else if (perm)
               begin
                  n.cmd.hash_start = 1'b1;
                  ev[`LRG_EV_HSTART] = 1'b1;
               end
            end
            `LRG_A_HASH_DATA:
            begin
               if (perm) // RULE1
               begin
                  n.cmd.hash_data = 1'b1;
                  n.cmd.data      = wr_data;
               end
            end
            `LRG_A_HASH_END:
            begin
               if (perm) // RULE1
               begin
                  n.cmd.hash_end = 1'b1; // RULE6
                  n.grant        = 1'b0;
                  ev[`LRG_EV_HEND]  = 1'b1;
                  ev[`LRG_EV_GRANT] = 1'b1;
               end
            end
            // Read-only registers and holes ignore writes
            default: n.csum = n.csum; // RULE11
         endcase
      end

      // Set wins over a clear in the same cycle
      ev[`LRG_EV_CORE] = core_evt;
      n.int_sts = (r.int_sts & ~clr) | ev;
      n.irq     = |(n.int_sts & n.int_en);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         r          <= '0;
         r.scl_q    <= 1'b1;
         r.sda_q    <= 1'b1;
         r.dev_addr <= `LRG_DEV_ADDR_RST;
      end
      else
      begin
         r <= n;
      end
   end

   assign sda_o     = r.sda_o;
   assign sda_oe    = r.sda_oe;
   assign bus_rdata = r.bus_rdata;
   assign cmd       = r.cmd;
   assign irq       = r.irq;

endmodule : lrg_gate
`default_nettype wire

// >>> tb/lrg_gate_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "lrg_regs.svh"
module lrg_gate_sva
   import lrg_pkg::*;
(
   input wire logic         clk,
   input wire logic         rst_n,
   input wire logic         scl_i,
   input wire logic         sda_i,
   input wire logic         sda_o,
   input wire logic         sda_oe,
   input wire lrg_bus_req_t bus_req,
   input wire logic [31:0]  bus_rdata,
   input wire logic         core_busy,
   input wire logic [7:0]   core_sts,
   input wire logic [7:0]   core_fifo_data,
   input wire logic         core_evt,
   input wire lrg_cmd_t     cmd,
   input wire logic         irq
);
   default clocking dcb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   rdata_idle_a: assert property (!bus_req.rd |=> bus_rdata == 32'h0000_0000)
      else $error("read data outside a read cycle");
   rdata_unmap_a: assert property (bus_req.rd && (bus_req.addr[1:0] != 2'h0
      || bus_req.addr > `LRG_B_DEV_ADDR) |=> bus_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   mask_quiet_a: assert property (bus_req.wr && bus_req.addr == `LRG_B_INT_MASK
      && bus_req.wdata[5:0] == 6'h00 |-> ##[1:2] !irq)
      else $error("interrupt stays up with all masked");
   one_cmd_a: assert property ($onehot0({cmd.fifo_wr, cmd.fifo_pop, cmd.sts_wr,
      cmd.hash_start, cmd.hash_data, cmd.hash_end}))
      else $error("several command flags at once");
   byte_pulse_a: assert property (cmd.fifo_wr |=> !cmd.fifo_wr)
      else $error("command byte flag longer than a cycle");
   hash_pulse_a: assert property (cmd.hash_start |=> !cmd.hash_start && !cmd.hash_end)
      else $error("hash start flag malformed");
   sda_edge_a: assert property ($changed(sda_oe) |-> !$past(scl_i, 3) || !$past(scl_i, 4))
      else $error("data line moved while clock high");
   drive_low_a: assert property (sda_oe |-> !sda_o)
      else $error("data line driven high");
   bit_hold_a: assert property ($rose(sda_oe) |=> sda_oe [*3])
      else $error("driven bit too short");
endmodule : lrg_gate_sva

bind lrg_gate lrg_gate_sva chk_u (.clk(clk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe(sda_oe), .bus_req(bus_req), .bus_rdata(bus_rdata),
   .core_busy(core_busy), .core_sts(core_sts), .core_fifo_data(core_fifo_data),
   .core_evt(core_evt), .cmd(cmd), .irq(irq));
`default_nettype wire

// >>> tb/lrg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lrg_host_model
#(
   parameter int HALF_NS  = 40,
   parameter int RETRY_NS = 2000000
)(
   output var  logic scl,
   output var  logic sda_pull,
   input  wire logic sda
);
   initial
   begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   task automatic cyc(input logic b, output logic r);
      #(HALF_NS / 2) sda_pull = !b;
      #(HALF_NS / 2) scl = 1'b1;
      #HALF_NS r = sda;
      scl = 1'b0;
   endtask : cyc

   // Also repeated start: line released before the clock rises
   task automatic start();
      #HALF_NS sda_pull = 1'b0;
      #HALF_NS scl = 1'b1;
      #HALF_NS sda_pull = 1'b1;
      #HALF_NS scl = 1'b0;
   endtask : start

   task automatic stop();
      #HALF_NS sda_pull = 1'b1;
      #HALF_NS scl = 1'b1;
      #HALF_NS sda_pull = 1'b0;
      #HALF_NS;
   endtask : stop

   task automatic put(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         cyc(b[i], r);
      cyc(1'b1, r);
      ack = !r;
   endtask : put

   task automatic get(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         cyc(1'b1, r);
         b[i] = r;
      end
      cyc(last, r);
   endtask : get

   task automatic write_frame(input logic [6:0] da, input logic [7:0] sub,
                              input logic [7:0] d, input logic retry, output logic ok);
      for (int n = 0; n < 2; n++)
      begin
         start();
         put({da, 1'b0}, ok);
         if (ok)
            put(sub, ok);
         if (ok)
            put(d, ok);
         stop();
         if (ok || !retry)
            break;
         #RETRY_NS;
      end
   endtask : write_frame

   task automatic read_frame(input logic [6:0] da, input logic [7:0] sub,
                             output logic [7:0] d, output logic ok);
      start();
      put({da, 1'b0}, ok);
      if (ok)
         put(sub, ok);
      if (ok)
      begin
         start();
         put({da, 1'b1}, ok);
      end
      if (ok)
         get(1'b1, d);
      stop();
   endtask : read_frame
endmodule : lrg_host_model
`default_nettype wire

// >>> tb/test_locality_register_gate.sv
`timescale 1ns/1ps
`default_nettype none
`include "lrg_regs.svh"
module test_locality_register_gate;
   import lrg_pkg::*;
   localparam logic [6:0] DEV = 7'h2E;
   logic clk, rst_n, scl, sda, sda_pull, sda_o, sda_oe, core_busy, core_evt, irq, ok, seen_clr;
   logic [7:0] core_sts, core_fifo_data, rb, r, sum, seen_d;
   logic [5:0] seen_f;
   logic [31:0] bus_rdata, d;
   lrg_bus_req_t bus_req;
   lrg_cmd_t cmd;
   int errors, checked;
   logic [7:0] gated [4] = '{`LRG_A_STS, `LRG_A_FIFO, `LRG_A_HASH_DATA, `LRG_A_HASH_END};
   logic [7:0] ro_a [4] = '{`LRG_A_ID, `LRG_A_REV, `LRG_A_CAP, `LRG_A_DATA_CSUM};
   logic [7:0] ro_v [4] = '{8'h5A, 8'h01, 8'h00, 8'h00};
   logic [7:0] rw_a [3] = '{`LRG_A_LOC_SEL, `LRG_A_INT_EN, `LRG_A_CSUM_EN};
   logic [7:0] rw_m [3] = '{8'hFF, 8'h3F, 8'h01};

   lrg_gate dut_u (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .bus_req(bus_req), .bus_rdata(bus_rdata), .core_busy(core_busy),
      .core_sts(core_sts), .core_fifo_data(core_fifo_data), .core_evt(core_evt),
      .cmd(cmd), .irq(irq));
   lrg_host_model #(.HALF_NS(40), .RETRY_NS(20000)) host_u (.scl(scl), .sda_pull(sda_pull),
      .sda(sda));
   assign sda = !sda_pull && !(sda_oe && !sda_o);

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      // Only this process drives the flag record
      if (seen_clr)
         seen_f <= '0;
      else
         seen_f <= seen_f | {cmd.fifo_wr, cmd.fifo_pop, cmd.sts_wr, cmd.hash_start,
                             cmd.hash_data, cmd.hash_end};
      if (cmd.fifo_wr | cmd.sts_wr | cmd.hash_data)
         seen_d <= cmd.data;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge clk);
      bus_req <= '0;
   endtask : bus_wr

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(posedge clk);
      bus_req <= '0;
      #1 v = bus_rdata;
   endtask : bus_rd

   // Pin moves kept off the clock edge
   task automatic lw(input logic [7:0] sub, input logic [7:0] v, input logic [5:0] f);
      seen_clr <= 1'b1;
      @(posedge clk);
      seen_clr <= 1'b0;
      #3;
      host_u.write_frame(DEV, sub, v, 1'b0, ok);
      repeat (4) @(posedge clk);
      check(ok, 1'b1);
      check(seen_f, f);
   endtask : lw

   task automatic lr(input logic [7:0] sub, input logic [7:0] exp);
      seen_clr <= 1'b1;
      @(posedge clk);
      seen_clr <= 1'b0;
      #3;
      host_u.read_frame(DEV, sub, rb, ok);
      @(posedge clk);
      check(ok, 1'b1);
      check(rb, exp);
   endtask : lr

   initial
   begin
      #800000;
      errors++;
      print_verdict();
   end

   initial
   begin
      rst_n = 1'b0;
      bus_req = '0;
      core_busy = 1'b0;
      core_evt = 1'b0;
      core_sts = 8'h00;
      core_fifo_data = 8'h00;
      seen_clr = 1'b1;
      void'($urandom(17490));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      bus_rd(`LRG_B_DEV_ADDR, d);
      check(d, 32'h0000_002E);
      bus_rd(8'h20, d);
      check(d, 32'h0000_0000);
      bus_wr(`LRG_B_INT_MASK, 32'h0000_0020);
      core_evt <= 1'b1;
      @(posedge clk);
      core_evt <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check(irq, 1'b1);
      bus_wr(`LRG_B_INT_MASK, 32'h0000_0000);
      repeat (2) @(posedge clk);
      #1 check(irq, 1'b0);
      bus_wr(`LRG_B_INT_MASK, 32'h0000_0020);
      bus_rd(`LRG_B_INT_STS, d);
      check(d, 32'h0000_0020);
      repeat (2) @(posedge clk);
      #1 check(irq, 1'b0);
      @(posedge clk);
      #3 host_u.write_frame(7'h2F, `LRG_A_LOC_SEL, 8'h01, 1'b0, ok);
      @(posedge clk);
      check(ok, 1'b0);
      foreach (gated[i])
      begin
         lw(gated[i], 8'($urandom), 6'h00);
         lr(gated[i], 8'hFF);
      end
      foreach (ro_a[i])
      begin
         lw(ro_a[i], ~ro_v[i], 6'h00);
         lr(ro_a[i], ro_v[i]);
      end
      foreach (rw_a[i])
      begin
         r = 8'($urandom);
         lw(rw_a[i], r, 6'h00);
         lr(rw_a[i], r & rw_m[i]);
      end
      bus_wr(`LRG_B_DEV_ADDR, 32'h0000_0033);
      #3 host_u.write_frame(7'h33, `LRG_A_DEV_ADDR, 8'h2E, 1'b0, ok);
      @(posedge clk);
      check(ok, 1'b1);
      lr(`LRG_A_DEV_ADDR, 8'h2E);
      lw(`LRG_A_LOC_SEL, 8'h01, 6'h00);
      lw(`LRG_A_ACCESS, 8'h02, 6'h00);
      lr(`LRG_A_ACCESS, 8'hA0);
      lw(`LRG_A_LOC_SEL, 8'h02, 6'h00);
      lw(`LRG_A_HASH_START, 8'h00, 6'h00);
      lw(`LRG_A_LOC_SEL, 8'h01, 6'h00);
      lw(`LRG_A_ACCESS, 8'h20, 6'h00);
      lw(`LRG_A_LOC_SEL, 8'h00, 6'h00);
      lw(`LRG_A_HASH_START, 8'h00, 6'h04);
      bus_rd(`LRG_B_STATE, d);
      check(d, 32'h0001_0400);
      lw(`LRG_A_HASH_DATA, 8'h11, 6'h00);
      lw(`LRG_A_LOC_SEL, 8'h04, 6'h00);
      lr(`LRG_A_ACCESS, 8'hA0);
      lw(`LRG_A_CSUM_EN, 8'h01, 6'h00);
      sum = 8'h00;
      repeat (6)
      begin
         r = 8'($urandom);
         sum += r;
         lw(`LRG_A_FIFO, r, 6'h20);
         check(seen_d, r);
      end
      lr(`LRG_A_DATA_CSUM, sum);
      {core_sts, core_fifo_data} <= 16'($urandom);
      @(posedge clk);
      lr(`LRG_A_STS, core_sts);
      lr(`LRG_A_FIFO, core_fifo_data);
      check(seen_f, 6'h10);
      lw(`LRG_A_STS, ~r, 6'h08);
      check(seen_d, 8'(~r));
      lw(`LRG_A_HASH_DATA, r, 6'h02);
      check(seen_d, r);
      lw(`LRG_A_HASH_END, 8'h00, 6'h01);
      bus_rd(`LRG_B_STATE, d);
      // Grant flag drops; the last holder's locality stays on show
      check(d, 32'h0000_0404);
      lr(`LRG_A_INT_STS, 8'h17);
      lw(`LRG_A_INT_STS, 8'h3F, 6'h00);
      lr(`LRG_A_INT_STS, 8'h00);
      core_busy <= 1'b1;
      fork
         #3 host_u.write_frame(DEV, `LRG_A_LOC_SEL, 8'h02, 1'b1, ok);
         begin
            repeat (400) @(posedge clk);
            core_busy <= 1'b0;
         end
      join
      @(posedge clk);
      check(ok, 1'b1);
      lr(`LRG_A_LOC_SEL, 8'h02);
      bus_rd(`LRG_B_INT_STS, d);
      check(d & 32'h0000_0008, 32'h0000_0008);
      print_verdict();
   end
endmodule : test_locality_register_gate
`default_nettype wire
